// file: rtl/gao_gate_ctrl.v
// Decided for this implementation: strobed register access and the register offsets.
`include "gao_regs.vh"
// ==========================================
// Gate operator advanced options controller
module gao_gate_ctrl #(
  parameter TICK_CYCLES = `GAO_CLK_HZ * `GAO_TICK_S,
  parameter SUP_S       = `GAO_SUP_S
) (
  input  wire        mclk,
  input  wire        arst_n,
  input  wire [2:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr_stb,
  input  wire        rd_stb,
  output reg  [31:0] rdata_reg,
  input  wire        open_btn,
  input  wire        close_btn,
  input  wire        stop_btn,
  input  wire        fire_in,
  input  wire        rev_loop,
  input  wire        shadow_loop,
  input  wire        obst_open,
  input  wire        obst_close,
  input  wire        entrap_in,
  input  wire        lim_open,
  input  wire        lim_close,
  input  wire        enter_btn,
  input  wire        show_count,
  input  wire        auto_close,
  input  wire        link_open_in,
  input  wire        link_close_in,
  input  wire        rf_access,
  input  wire [1:0]  rf_obst_act,
  input  wire [1:0]  rf_obst_sup,
  input  wire [1:0]  rf_obst_low,
  output reg         motor_open_reg,
  output reg         motor_close_reg,
  output reg         brake_reg,
  output reg         link_open_reg,
  output reg         link_close_reg,
  output reg         service_due_lamp,
  output reg         alarm_beep_reg,
  output reg         err15_reg,
  output reg  [7:0]  disp_pair_reg
);
  localparam ST_IDLE = 3'h0;
  localparam ST_OPEN = 3'h1;
  localparam ST_CLOSE = 3'h2;
  localparam ST_REVW = 3'h3;
  localparam ST_BRKW = 3'h4;
  localparam ST_TGHOLD = 3'h5;

  // ==========================================
  // Helper functions
  function [31:0] bcd_inc;
    input [31:0] v;
    integer i;
    reg c;
    begin
      bcd_inc = v;
      c = 1'b1;
      for (i = 0; i < 8; i = i + 1) begin
        if (c) begin
          if (v[4*i +: 4] == 4'h9) begin
            bcd_inc[4*i +: 4] = 4'h0;
          end else begin
            bcd_inc[4*i +: 4] = v[4*i +: 4] + 4'h1;
            c = 1'b0;
          end
        end
      end
    end
  endfunction

  function [14:0] thr;
    input [1:0] sel;
    begin
      case (sel)
        2'h0:    thr = 15'h1388;
        2'h1:    thr = 15'h2710;
        2'h2:    thr = 15'h3A98;
        default: thr = 15'h61A8;
      endcase
    end
  endfunction

  // Role decode for obstacle transmitters: oo, oc, rev, stop
  function [3:0] role_hit;
    input [1:0] role;
    input       act;
    begin
      role_hit = act ? (4'h1 << role) : 4'h0;
    end
  endfunction

  // ==========================================
  // Reset release and pin synchronisers
  reg  [1:0]  rst_sync_reg;
  wire        rst_n = rst_sync_reg[1];
  wire [22:0] pin_raw = {rf_obst_low, rf_obst_sup, rf_obst_act, rf_access,
                         link_close_in, link_open_in, auto_close, show_count,
                         enter_btn, lim_close, lim_open, entrap_in, obst_close,
                         obst_open, shadow_loop, rev_loop, fire_in, stop_btn,
                         close_btn, open_btn};
  reg  [22:0] s1_reg;
  reg  [22:0] s2_reg;
  reg  [22:0] prev_reg;
  wire [22:0] rise = s2_reg & ~prev_reg;
  wire [22:0] fall = ~s2_reg & prev_reg;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  // Two-stage sync plus edge history
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg   <= 23'h00_0000;
      s2_reg   <= 23'h00_0000;
      prev_reg <= 23'h00_0000;
    end else begin
      s1_reg   <= pin_raw;
      s2_reg   <= s1_reg;
      prev_reg <= s2_reg;
    end
  end

  // ==========================================
  // Settings and counters
  reg  [31:0] cfg_reg;
  reg  [6:0]  mid_reg;
  reg  [31:0] cyc_reg;
  reg  [14:0] maint_reg;
  reg  [5:0]  acc_cnt_reg;
  reg  [1:0]  obs_cnt_reg;
  reg  [2:0]  st_reg;
  reg  [2:0]  st_next;
  reg  [2:0]  dir_reg;
  reg  [2:0]  dir_next;
  reg         full_reg;
  reg         full_next;
  reg         fire_run_reg;
  reg  [6:0]  sec_reg;
  reg         restart_reg;
  reg         opened_reg;
  reg  [1:0]  hold_sec_reg;
  reg  [1:0]  pair_idx_reg;
  reg  [1:0]  miss_reg [0:1];
  reg  [11:0] sup_sec_reg [0:1];
  wire        tick;
  integer     k;

  wire radio_on = cfg_reg[`GAO_B_RADIO];
  wire hold_o   = cfg_reg[`GAO_B_HOLD_O];
  wire hold_c   = cfg_reg[`GAO_B_HOLD_C];
  wire atg      = cfg_reg[`GAO_B_ATG];
  wire dual     = cfg_reg[`GAO_B_DUAL];
  wire [1:0] learned = {obs_cnt_reg == `GAO_OBS_MAX, obs_cnt_reg != 2'h0};

  // Obstacle transmitters mapped onto their roles
  wire [3:0] tx_hit = role_hit(cfg_reg[`GAO_F_ROLE0], s2_reg[17] & learned[0] & radio_on)
                    | role_hit(cfg_reg[`GAO_F_ROLE1], s2_reg[18] & learned[1] & radio_on); // see R19
  wire oo = s2_reg[6] | tx_hit[0];
  wire oc = s2_reg[7] | tx_hit[1];
  wire rv = s2_reg[4] | tx_hit[2];
  wire sp = rise[2] | tx_hit[3];
  wire acc_ok = rise[16] & radio_on & (acc_cnt_reg != 6'h00); // see R18
  wire from_link = rise[14] | rise[15];
  wire open_req = rise[0] | rise[3] | rise[14] | acc_ok;
  wire close_req = rise[1] | rise[15] | rise[13];
  wire close_blk = s2_reg[5] & s2_reg[9]; // see R07
  wire open_blk = s2_reg[5] & s2_reg[10] & cfg_reg[`GAO_B_OBLK]; // see R08
  wire mid_on = (mid_reg != 7'h00) & ~dual & ~full_reg; // see R13 R15
  // Software clears of the counts
  wire ctrl_wr = wr_stb && (addr == `GAO_A_CTRL);
  wire clr_cyc = ctrl_wr & wdata[`GAO_C_CLRCYC]; // see R11
  wire clr_mnt = ctrl_wr & wdata[`GAO_C_CLRMNT];

  gao_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk     (mclk),
    .rst_n   (rst_n),
    .restart (restart_reg),
    .tick_reg(tick)
  );

  // ==========================================
  // Motion state machine, next state
  always @* begin
    st_next   = st_reg;
    dir_next  = dir_reg;
    full_next = full_reg | rise[3];
    case (st_reg)
      ST_IDLE: begin
        if (open_req & ~s2_reg[9] & ~open_blk) begin
          st_next = ST_OPEN; // see R04
        end else if (close_req & ~s2_reg[10] & ~close_blk) begin
          st_next = ST_CLOSE; // see R16
        end else if (atg & fall[5] & s2_reg[9]) begin
          st_next = ST_CLOSE; // see R17
        end
      end
      ST_OPEN: begin
        if (sp | s2_reg[9] | oo) begin
          st_next = ST_BRKW;
        end else if (hold_o & ~s2_reg[0] & ~fire_run_reg) begin
          st_next = ST_BRKW; // see R05
        end else if (close_req & ~close_blk) begin
          st_next  = ST_REVW; // see R01
          dir_next = ST_CLOSE;
        end else if (mid_on & (sec_reg >= mid_reg)) begin
          if (s2_reg[0]) begin
            full_next = 1'b1; // see R14
          end else begin
            st_next = ST_BRKW;
          end
        end
      end
      ST_CLOSE: begin
        if (sp | s2_reg[10] | (hold_c & ~s2_reg[1])) begin
          st_next = ST_BRKW; // see R05
        end else if (oc | s2_reg[8]) begin
          st_next   = ST_OPEN; // see R02 R14
          full_next = 1'b1;
        end else if (rv | open_req) begin
          st_next   = ST_REVW; // see R01
          dir_next  = ST_OPEN;
          full_next = full_reg | rv | rise[3]; // see R14
        end else if (atg & rise[5]) begin
          st_next = ST_TGHOLD; // see R17
        end
      end
      ST_REVW: begin
        if (sp) begin
          st_next = ST_BRKW;
        end else if (sec_reg >= {3'h0, cfg_reg[`GAO_F_REV]}) begin
          st_next = dir_reg; // see R01
        end
      end
      ST_TGHOLD: begin
        if (sp) begin
          st_next = ST_BRKW;
        end else if (fall[5]) begin
          st_next = ST_CLOSE; // see R17
        end
      end
      ST_BRKW: begin
        if (sec_reg >= {5'h00, cfg_reg[`GAO_F_BRK]}) begin
          st_next = ST_IDLE; // see R03
        end
      end
      default: st_next = ST_IDLE;
    endcase
  end

  // ==========================================
  // Motion state, timers, motor, brake and link outputs
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg          <= ST_IDLE;
      dir_reg         <= ST_IDLE;
      full_reg        <= 1'b0;
      fire_run_reg    <= 1'b0;
      sec_reg         <= 7'h00;
      restart_reg     <= 1'b0;
      motor_open_reg  <= 1'b0;
      motor_close_reg <= 1'b0;
      brake_reg       <= 1'b1;
      link_open_reg   <= 1'b0;
      link_close_reg  <= 1'b0;
    end else begin
      st_reg          <= st_next;
      dir_reg         <= dir_next;
      restart_reg     <= (st_next != st_reg); // see R24
      motor_open_reg  <= (st_next == ST_OPEN);
      motor_close_reg <= (st_next == ST_CLOSE);
      if (st_next != st_reg) begin
        sec_reg <= 7'h00; // see R24
      end else if (tick & (sec_reg != 7'h7F)) begin
        sec_reg <= sec_reg + 7'h01;
      end
      // Brake released while running, applied after the delay
      if (st_next == ST_OPEN || st_next == ST_CLOSE) begin
        brake_reg <= 1'b0;
      end else if (st_reg == ST_BRKW && st_next == ST_IDLE) begin
        brake_reg <= 1'b1; // see R03
      end
      if (st_next == ST_IDLE) begin
        full_reg     <= 1'b0;
        fire_run_reg <= 1'b0;
      end else begin
        full_reg     <= full_next;
        fire_run_reg <= fire_run_reg | rise[3];
      end
      // Local activation relayed to the partner for one second
      if (st_reg == ST_IDLE && st_next != ST_IDLE && !from_link && dual) begin
        link_open_reg  <= (st_next == ST_OPEN); // see R23
        link_close_reg <= (st_next == ST_CLOSE);
      end else if (tick) begin
        link_open_reg  <= 1'b0;
        link_close_reg <= 1'b0;
      end
    end
  end

  // ==========================================
  // Cycle count, service lamp, display and supervision
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_reg          <= 32'h0000_0000;
      maint_reg        <= 15'h0000;
      opened_reg       <= 1'b0;
      hold_sec_reg     <= 2'h0;
      pair_idx_reg     <= 2'h0;
      disp_pair_reg    <= 8'h00;
      service_due_lamp <= 1'b0;
      alarm_beep_reg   <= 1'b0;
      for (k = 0; k < 2; k = k + 1) begin
        miss_reg[k]    <= 2'h0;
        sup_sec_reg[k] <= 12'h000;
      end
    end else begin
      // Closing to the limit ends an opened cycle; a clear beats the count
      if (rise[9]) begin
        opened_reg <= 1'b1;
      end else if (rise[10]) begin
        opened_reg <= 1'b0;
      end
      if ((s2_reg[11] & s2_reg[12] & (hold_sec_reg == `GAO_HOLD_CLR_S)) | clr_cyc) begin
        cyc_reg   <= 32'h0000_0000; // see R10 R11
        maint_reg <= 15'h0000;
      end else if (rise[10] & opened_reg) begin
        cyc_reg <= bcd_inc(cyc_reg); // see R09
        if (clr_mnt) begin
          maint_reg <= 15'h0000;
        end else if (maint_reg != 15'h7FFF) begin
          maint_reg <= maint_reg + 15'h0001;
        end
      end else if (clr_mnt) begin
        maint_reg <= 15'h0000;
      end
      // Enter hold timer, counted only while the count is shown
      if (~(s2_reg[11] & s2_reg[12])) begin
        hold_sec_reg <= 2'h0;
      end else if (tick & (hold_sec_reg != 2'h3)) begin
        hold_sec_reg <= hold_sec_reg + 2'h1; // see R10
      end
      // Scroll two digits per second, most significant first
      if (!s2_reg[12]) begin
        pair_idx_reg  <= 2'h0;
        disp_pair_reg <= 8'h00;
      end else begin
        disp_pair_reg <= cyc_reg[8*(3-pair_idx_reg) +: 8]; // see R09
        if (tick) begin
          pair_idx_reg <= pair_idx_reg + 2'h1;
        end
      end
      service_due_lamp <= (maint_reg > thr(cfg_reg[`GAO_F_MSEL])); // see R12
      // Missed report counting per learned transmitter
      for (k = 0; k < 2; k = k + 1) begin
        if (rise[19+k] | ~learned[k]) begin
          miss_reg[k]    <= 2'h0;
          sup_sec_reg[k] <= 12'h000;
        end else if (tick) begin
          if (sup_sec_reg[k] == SUP_S - 1) begin
            sup_sec_reg[k] <= 12'h000;
            if (miss_reg[k] != 2'h3) begin
              miss_reg[k] <= miss_reg[k] + 2'h1;
            end
          end else begin
            sup_sec_reg[k] <= sup_sec_reg[k] + 12'h001;
          end
        end
      end
      alarm_beep_reg <= cfg_reg[`GAO_B_MON] & radio_on &
        ((learned[0] & ((miss_reg[0] >= `GAO_MISS_MAX) | s2_reg[21])) |
         (learned[1] & ((miss_reg[1] >= `GAO_MISS_MAX) | s2_reg[22]))); // see R20
    end
  end

  // ==========================================
  // Register writes, transmitter store, setting checks
  wire rev_bad = (cfg_reg[`GAO_F_REV] < `GAO_REV_MIN) | (cfg_reg[`GAO_F_REV] > `GAO_REV_MAX);
  wire mid_bad = (mid_reg > `GAO_MID_MAX);
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg     <= `GAO_CFG_RST;
      mid_reg     <= 7'h00;
      acc_cnt_reg <= 6'h00;
      obs_cnt_reg <= 2'h0;
      err15_reg   <= 1'b0;
    end else if (wr_stb) begin
      case (addr)
        `GAO_A_CFG: cfg_reg <= wdata;
        `GAO_A_MID: mid_reg <= wdata[6:0];
        `GAO_A_CTRL: begin
          if (wdata[`GAO_C_FACT]) begin
            cfg_reg <= `GAO_CFG_RST; // see R21
            mid_reg <= 7'h00;
          end else if (wdata[`GAO_C_EXIT]) begin
            err15_reg <= rev_bad | mid_bad; // see R22
            if (rev_bad) begin
              cfg_reg[`GAO_F_REV] <= `GAO_REV_MIN;
            end
            if (mid_bad) begin
              mid_reg <= `GAO_MID_MIN;
            end
          end
          if (wdata[`GAO_C_DEL_A]) begin
            acc_cnt_reg <= 6'h00;
          end else if (wdata[`GAO_C_LRN_A] & radio_on & (acc_cnt_reg < `GAO_ACC_MAX)) begin
            acc_cnt_reg <= acc_cnt_reg + 6'h01; // see R18
          end
          if (wdata[`GAO_C_DEL_O]) begin
            obs_cnt_reg <= 2'h0;
          end else if (wdata[`GAO_C_LRN_O] & radio_on & (obs_cnt_reg < `GAO_OBS_MAX)) begin
            obs_cnt_reg <= obs_cnt_reg + 2'h1; // see R18
          end
        end
        default: ;
      endcase
    end
  end

  // ==========================================
  // Read data, valid the cycle after the strobe
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_stb) begin
      case (addr)
        `GAO_A_CFG:   rdata_reg <= cfg_reg;
        `GAO_A_MID:   rdata_reg <= {25'h000_0000, mid_reg};
        `GAO_A_STAT:  rdata_reg <= {20'h0_0000, ~hold_c, ~hold_o, err15_reg, alarm_beep_reg,
                                    service_due_lamp, brake_reg, full_reg, opened_reg,
                                    1'b0, st_reg}; // see R06
        `GAO_A_CYC:   rdata_reg <= cyc_reg;
        `GAO_A_MAINT: rdata_reg <= {17'h0_0000, maint_reg};
        `GAO_A_TX:    rdata_reg <= {22'h00_0000, obs_cnt_reg, 2'h0, acc_cnt_reg};
        default:      rdata_reg <= 32'h0000_0000;
      endcase
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end
endmodule // gao_gate_ctrl

// file: rtl/gao_regs.vh
// Operation
// R01 - Pause a programmable reverse delay, default 1 s, 1..9 s, before reversing
// R02 - Entrapment-driven reversals skip the reverse delay
// R03 - Apply brake after programmable delay 0..3 s after running, default none
// R04 - Momentary press runs a full cycle; hold-to-run selectable per direction
// R05 - Releasing a hold-to-run button before the limit stops the gate
// R06 - Hold-to-run direction needs no monitored obstruction input
// R07 - Shadow loop at full open always blocks closing
// R08 - Optional: shadow loop at close limit blocks opening
// R09 - Count full cycles; display scrolls two digits at a time, left to right
// R10 - Enter held 2 s while count shown clears the cycle count
// R11 - Clearing the cycle count also clears the service lamp
// R12 - Service lamp lights above 5, 10, 15 or 25 thousand cycles, default 10k
// R13 - Mid-travel stop after 1..99 s of opening; default full open
// R14 - Fire, open held, close obstruction or reverse loop force full open
// R15 - Mid-travel stop inactive while paired operation enabled
// R16 - Anti-tailgate off: closing needs auto-close or close command
// R17 - Anti-tailgate on: close on shadow clear, stop on retrigger, then resume
// R18 - Radio, default on, stores up to 40 access and two obstacle transmitters
// R19 - Each obstacle transmitter acts as open/close obstruction, reverse or stop
// R20 - Monitoring on: two missed supervision reports start alarm beeping
// R21 - Factory default reloads settings, keeps transmitters
// R22 - Illegal settings raise error 15 on exit and force minimum values
// R23 - Paired operators signal each other to activate over a three-wire link
// R24 - Timers count seconds from one tick, restarted on each motion command
`ifndef GAO_REGS_VH
`define GAO_REGS_VH
// ==========================================
// Register indices
`define GAO_A_CFG      3'h0
`define GAO_A_MID      3'h1
`define GAO_A_CTRL     3'h2
`define GAO_A_STAT     3'h3
`define GAO_A_CYC      3'h4
`define GAO_A_MAINT    3'h5
`define GAO_A_TX       3'h6
// ==========================================
// Configuration fields
`define GAO_F_REV      3:0
`define GAO_F_BRK      5:4
`define GAO_B_HOLD_O   8
`define GAO_B_HOLD_C   9
`define GAO_B_OBLK     10
`define GAO_B_ATG      11
`define GAO_B_RADIO    12
`define GAO_B_MON      13
`define GAO_B_DUAL     14
`define GAO_F_MSEL     17:16
`define GAO_F_ROLE0    21:20
`define GAO_F_ROLE1    23:22
`define GAO_CFG_RST    32'h0001_1001
`define GAO_REV_MIN    4'h1
`define GAO_REV_MAX    4'h9
`define GAO_MID_MAX    7'h63
`define GAO_MID_MIN    7'h01
// Control pulse bits
`define GAO_C_CLRCYC   0
`define GAO_C_CLRMNT   1
`define GAO_C_FACT     2
`define GAO_C_EXIT     3
`define GAO_C_LRN_A    4
`define GAO_C_DEL_A    5
`define GAO_C_LRN_O    6
`define GAO_C_DEL_O    7
// ==========================================
// Limits and timing
`define GAO_ACC_MAX    6'h28
`define GAO_OBS_MAX    2'h2
`define GAO_MISS_MAX   2'h2
`define GAO_CLK_HZ     250000000
`define GAO_TICK_S     1
`define GAO_HOLD_CLR_S 2'h2
`define GAO_SUP_S      3600
`endif

// file: rtl/gao_tick.v
`include "gao_regs.vh"
// ==========================================
// One-second enable divider, restartable
module gao_tick #(
  parameter TICK_CYCLES = `GAO_CLK_HZ * `GAO_TICK_S
) (
  input  wire clk,
  input  wire rst_n,
  input  wire restart,
  output reg  tick_reg
);
  reg [31:0] cnt_reg;

  // Count cycles, pulse once per period
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg  <= 32'h0000_0000;
      tick_reg <= 1'b0;
    end else if (restart) begin // see R24
      cnt_reg  <= 32'h0000_0000;
      tick_reg <= 1'b0;
    end else if (cnt_reg == TICK_CYCLES - 1) begin
      cnt_reg  <= 32'h0000_0000;
      tick_reg <= 1'b1;
    end else begin
      cnt_reg  <= cnt_reg + 32'h0000_0001;
      tick_reg <= 1'b0;
    end
  end
endmodule // gao_tick

// file: test/gao_gate_model.sv
// ==========================================
// Gate leaf with end-of-travel switches
module gao_gate_model #(
  parameter int TRAVEL = 40
) (
  input  logic mclk,
  input  logic run_open,
  input  logic run_close,
  output logic lim_open,
  output logic lim_close
);
  timeunit 1ns;
  timeprecision 100ps;
  int pos = 0;
  // One step per cycle while driven, stays put when idle
  always @(posedge mclk) begin
    if (run_open && pos < TRAVEL)
      pos <= pos + 1;
    else if (run_close && pos > 0)
      pos <= pos - 1;
  end
  // Switches close only at the travel ends
  assign lim_open  = (pos == TRAVEL);
  assign lim_close = (pos == 0);
endmodule // gao_gate_model

// file: test/gao_gate_monitor.sv
`include "gao_regs.vh"
// ==========================================
// Port checks for the gate controller
module gao_gate_monitor #(
  parameter TICK_CYCLES = 10,
  parameter SUP_S       = 4
) (
  input logic        mclk,
  input logic        arst_n,
  input logic [2:0]  addr,
  input logic [31:0] wdata,
  input logic        wr_stb,
  input logic        rd_stb,
  input logic [31:0] rdata_reg,
  input logic        shadow_loop,
  input logic        lim_open,
  input logic        entrap_in,
  input logic        motor_open_reg,
  input logic        motor_close_reg,
  input logic        brake_reg,
  input logic        service_due_lamp,
  input logic        err15_reg
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Control writes that end programming or clear the counts
  wire exit_wr = wr_stb && addr == `GAO_A_CTRL && wdata[`GAO_C_EXIT];
  wire clr_wr  = wr_stb && addr == `GAO_A_CTRL && wdata[`GAO_C_CLRCYC];
  // Closing run hit by a fresh entrapment edge
  sequence s_close_hit;
    motor_close_reg && $rose(entrap_in);
  endsequence
  // Opening resumes 2 to 8 cycles later, with no reverse pause
  sequence s_reopen;
    ##[2:8] motor_open_reg;
  endsequence

  a_motor_excl: assert property (!(motor_open_reg && motor_close_reg))
    else $error("both motor directions driven");
  a_rev_gap: assert property ($fell(motor_open_reg) |-> !motor_close_reg [*8])
    else $error("close started without reverse pause");
  a_entrap_fast: assert property (s_close_hit |-> s_reopen)
    else $error("entrapment reversal was delayed");
  a_run_no_brake: assert property ((motor_open_reg || motor_close_reg) |-> !brake_reg)
    else $error("brake applied while running");
  a_shadow_hold: assert property ((shadow_loop && lim_open) [*5] |-> !$rose(motor_close_reg))
    else $error("closed while shadow loop held at open");
  a_err_exit: assert property ($rose(err15_reg) |-> $past(exit_wr) || $past(exit_wr, 2))
    else $error("error flag rose without exit");
  a_lamp_clear: assert property (clr_wr |-> ##[1:2] !service_due_lamp)
    else $error("service lamp kept after count clear");
  a_rdata_idle: assert property (!$past(rd_stb) |-> rdata_reg == 32'h0000_0000)
    else $error("read data outside read slot");
endmodule // gao_gate_monitor

bind gao_gate_ctrl gao_gate_monitor #(.TICK_CYCLES(TICK_CYCLES), .SUP_S(SUP_S)) mon_u (.*);

// file: test/tb_top.sv
`include "gao_regs.vh"
// ==========================================
// Gate controller bench
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int OPN = 0, CLS = 1, STP = 2, FIR = 3, RVL = 4, ENT = 5, ACL = 6, RFA = 7, LCL = 8;
  logic        mclk, arst_n, wr_stb, rd_stb, shadow_loop, enter_btn, show_count;
  logic        obst_open, obst_close, link_open_in;
  logic [2:0]  addr;
  logic [31:0] wdata, rdata_reg, d;
  logic [8:0]  pins;
  logic [1:0]  rf_obst_act, rf_obst_sup, rf_obst_low;
  logic        open_btn, close_btn, stop_btn, fire_in, rev_loop, entrap_in, auto_close;
  logic        rf_access, link_close_in, lim_open, lim_close;
  logic        motor_open_reg, motor_close_reg, brake_reg, link_open_reg, link_close_reg;
  logic        service_due_lamp, alarm_beep_reg, err15_reg;
  logic [7:0]  disp_pair_reg;
  int          errors = 0, n_compared = 0, cycles = 0;
  // Pulsed pins come from one vector
  assign {link_close_in, rf_access, auto_close, entrap_in, rev_loop, fire_in, stop_btn,
          close_btn, open_btn} = pins;

  gao_gate_ctrl #(.TICK_CYCLES(10), .SUP_S(4)) dut_u (.*);
  gao_gate_model #(.TRAVEL(40)) gate_u (.mclk(mclk), .run_open(motor_open_reg),
    .run_close(motor_close_reg), .lim_open(lim_open), .lim_close(lim_close));

  // Clock, 4 ns period
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      errors++;
      conclude();
    end
  end

  task automatic cy(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Limits and motor, sampled mid-cycle
  task automatic st(input logic [3:0] e);
    @(negedge mclk);
    ck({lim_open, lim_close, motor_open_reg, motor_close_reg}, e);
  endtask
  task automatic pulse(input int i, input int n);
    @(posedge mclk);
    pins[i] <= 1'b1;
    cy(n);
    pins[i] <= 1'b0;
  endtask
  task automatic wr(input logic [2:0] a, input logic [31:0] v);
    @(posedge mclk);
    addr   <= a;
    wdata  <= v;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge mclk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    @(negedge mclk);
    d = rdata_reg;
  endtask
  task automatic conclude;
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    arst_n = 1'b0;
    {wr_stb, rd_stb, addr, wdata, pins, shadow_loop, enter_btn, show_count} = '0;
    {obst_open, obst_close, link_open_in, rf_obst_act, rf_obst_sup, rf_obst_low} = '0;
    cy(8);
    arst_n <= 1'b1;
    cy(3);
    rd(`GAO_A_CFG);
    ck(d, 32'h0001_1001);
    rd(3'h7);
    ck(d, 32'h0000_0000);
    // Learned transmitter opens fully
    wr(`GAO_A_CTRL, 32'h0000_0010);
    rd(`GAO_A_TX);
    ck(d, 32'h0000_0001);
    pulse(RFA, 5);
    cy(5);
    st(4'b0010);
    cy(60);
    st(4'b1000);
    // Shadow loop at full open, then auto close
    cy(1);
    shadow_loop <= 1'b1;
    pulse(CLS, 5);
    cy(15);
    st(4'b1000);
    cy(1);
    shadow_loop <= 1'b0;
    cy(20);
    st(4'b1000);
    pulse(ACL, 5);
    cy(5);
    st(4'b0001);
    cy(60);
    st(4'b0100);
    rd(`GAO_A_CYC);
    ck(d, 32'h0000_0001);
    // Two second reverse pause, entrapment skips it
    wr(`GAO_A_CFG, 32'h0001_1002);
    pulse(OPN, 5);
    cy(20);
    pulse(CLS, 5);
    cy(13);
    st(4'b0000);
    cy(17);
    st(4'b0001);
    pulse(ENT, 3);
    cy(5);
    st(4'b0010);
    cy(50);
    st(4'b1000);
    // Reverse loop while closing, then stop
    pulse(LCL, 5);
    cy(15);
    pulse(RVL, 3);
    cy(25);
    st(4'b0010);
    pulse(STP, 3);
    cy(5);
    st(4'b0000);
    // Hold-to-run close released mid-travel
    wr(`GAO_A_CFG, 32'h0001_1201);
    pulse(CLS, 10);
    cy(4);
    st(4'b0000);
    pulse(FIR, 40);
    cy(2);
    st(4'b1000);
    // Illegal settings corrected on exit
    wr(`GAO_A_CFG, 32'h0001_1000);
    wr(`GAO_A_MID, 32'h0000_0064);
    wr(`GAO_A_CTRL, 32'h0000_0008);
    @(negedge mclk);
    ck(err15_reg, 32'h0000_0001);
    rd(`GAO_A_CFG);
    ck(d[3:0], 32'h0000_0001);
    rd(`GAO_A_MID);
    ck(d, 32'h0000_0001);
    wr(`GAO_A_CFG, 32'h0001_1001);
    wr(`GAO_A_CTRL, 32'h0000_0008);
    @(negedge mclk);
    ck(err15_reg, 32'h0000_0000);
    // Monitored obstacle transmitter trouble
    wr(`GAO_A_CTRL, 32'h0000_0040);
    wr(`GAO_A_CFG, 32'h0001_3001);
    cy(1);
    rf_obst_low <= 2'b01;
    cy(8);
    @(negedge mclk);
    ck(alarm_beep_reg, 32'h0000_0001);
    // Enter held while count shown clears it
    cy(1);
    show_count <= 1'b1;
    enter_btn  <= 1'b1;
    cy(40);
    enter_btn  <= 1'b0;
    show_count <= 1'b0;
    rd(`GAO_A_CYC);
    ck(d, 32'h0000_0000);
    wr(`GAO_A_CTRL, 32'h0000_0001);
    @(negedge mclk);
    ck(service_due_lamp, 32'h0000_0000);
    // Paired start relayed to the partner
    wr(`GAO_A_CFG, 32'h0001_5001);
    pulse(CLS, 3);
    @(negedge mclk);
    ck({link_open_reg, link_close_reg}, 32'h0000_0001);
    // Factory default keeps stored transmitters
    wr(`GAO_A_CTRL, 32'h0000_0004);
    rd(`GAO_A_CFG);
    ck(d, 32'h0001_1001);
    rd(`GAO_A_TX);
    ck(d, 32'h0000_0101);
    conclude();
  end
endmodule // tb_top
